// *** design/vic_pkg.sv ***
package vic_pkg;

  // ---------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_EN_SET_LO = 12'h100;
  localparam logic [11:0] OFS_EN_SET_HI = 12'h104;
  localparam logic [11:0] OFS_EN_CLR_LO = 12'h180;
  localparam logic [11:0] OFS_EN_CLR_HI = 12'h184;
  localparam logic [11:0] OFS_PEND_SET_LO = 12'h200;
  localparam logic [11:0] OFS_PEND_SET_HI = 12'h204;
  localparam logic [11:0] OFS_PEND_CLR_LO = 12'h280;
  localparam logic [11:0] OFS_PEND_CLR_HI = 12'h284;
  localparam logic [11:0] OFS_ACTIVE_LO = 12'h300;
  localparam logic [11:0] OFS_ACTIVE_HI = 12'h304;
  localparam logic [11:0] OFS_PRIO_BASE = 12'h400;
  localparam logic [11:0] OFS_SYS_CTRL = 12'hD10;

  // ---------------------------------------------
  // interrupt numbering and fields
  // ---------------------------------------------
  localparam int NUM_IRQ = 36;
  localparam int IRQ_FIRST = 12;
  localparam int LO_FIELD_LSB = 12;
  localparam int HI_FIELD_W = 4;
  localparam int NUM_PRIO_SLOTS = 256;
  localparam int PRIO_WORDS = 64;
  localparam int NEST_LEVELS = 2;
  localparam logic [3:0] PRIO_RESET = 4'h0;

  // ---------------------------------------------
  // system control bit positions and reset
  // ---------------------------------------------
  localparam int SC_SYS_RESET = 31;
  localparam int SC_DEADLOCK = 6;
  localparam int SC_RAISE_EVENT = 5;
  localparam int SC_WAKE_ANY = 4;
  localparam int SC_WFI_AS_WFE = 3;
  localparam int SC_DEEP = 2;
  localparam int SC_SLEEP_EXIT = 1;
  localparam logic SC_BIT_RESET = 1'b0;

  typedef enum logic [1:0] {
    PWR_AWAKE,
    PWR_WAIT_IRQ,
    PWR_WAIT_EVT
  } power_state_t;

  // write data to per-interrupt vector (bit n = interrupt n)
  function automatic logic [NUM_IRQ-1:0] field_to_vec(input logic hi, input logic [31:0] d);
    field_to_vec = hi ? {d[3:0], 32'h0000_0000} : {4'h0, d[31:12], 12'h000};
  endfunction

  // per-interrupt vector to read data, reserved bits zero
  function automatic logic [31:0] vec_to_field(input logic hi, input logic [NUM_IRQ-1:0] v);
    vec_to_field = hi ? {28'h000_0000, v[35:32]} : {v[31:12], 12'h000};
  endfunction

endpackage

// *** design/vectored_interrupt_ctrl_regs.sv ***
`timescale 1ns/1ps

// Summary of operation
// - writing 1 to upper disable field clears enable of interrupts 32 and up
// - writing 1 to lower pending-set field pends interrupts 31 and below
// - writing 1 to upper pending-set field pends interrupts 32 and up
// - writing 1 to lower pending-clear field unpends interrupts 31 and below
// - writing 1 to upper pending-clear field unpends interrupts 32 and up
// - lower active field reads 1 while that interrupt is serviced
// - upper active field reads 1 while that interrupt is serviced
// - priority storage holds one 8-bit slot for each of 256 interrupts
// - four slots per word, interrupt n in byte n mod 4 of word n/4
// - only the upper nibble is stored; lower nibble reads zero
// - smaller priority value is the more urgent request
// - two nesting levels only; second-level handler is never preempted
// - writing 1 to bit 31 causes a system reset pulse; self-clearing
// - bit 6 at 0 enables deadlock handling, at 1 disables it
// - writing 1 to bit 5 raises a wake event
// - bit 4 set lets any pending interrupt wake event wait
// - a wake event while not waiting is remembered for next wait
// - bit 3 set makes wait-for-interrupt behave as event wait
// - bit 2 selects deep sleep when 1, ordinary sleep when 0
// - bit 1 set enters low power after returning from the last handler
// - writing 1 to lower enable field enables interrupts 31 and below
// - writing 1 to upper enable field enables interrupts 32 and up
// - writing 1 to lower disable field disables interrupts 31 and below
module vectored_interrupt_ctrl_regs
  import vic_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic [ADDR_W-1:0] i_addr, // register byte address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data, cycle after i_rd
  input wire logic [NUM_IRQ-1:0] i_irq_line, // peripheral lines, rising edge pends
  input wire logic i_event, // external wake event pulse
  input wire logic i_irq_ack, // core enters offered interrupt
  input wire logic i_irq_ret, // core returns from handler
  input wire logic i_wfi, // core executes wait-for-interrupt
  input wire logic i_wfe, // core executes wait-for-event
  output logic o_irq_req, // interrupt offered to core
  output logic [7:0] o_irq_num, // offered interrupt number
  output logic [1:0] o_nest_depth, // handlers in progress
  output logic o_sleep, // core held in low power
  output logic o_sleep_deep, // low power is deep sleep
  output logic o_wake, // wait completes, one cycle
  output logic o_sys_reset, // system reset pulse
  output logic o_deadlock_off // deadlock handling disabled
);

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  logic [NUM_IRQ-1:0] irq_enable;
  logic [NUM_IRQ-1:0] irq_pending;
  logic [NUM_IRQ-1:0] irq_active;
  logic [NUM_IRQ-1:0] line_q;
  logic [3:0] prio_mem [NUM_PRIO_SLOTS];
  logic [7:0] stack_num [NEST_LEVELS];
  logic [3:0] stack_prio [NEST_LEVELS];
  logic [1:0] depth;
  logic deadlock_off;
  logic wake_any_pending;
  logic wfi_as_wfe;
  logic deep_select;
  logic sleep_after_handler;
  logic event_flag;
  power_state_t pwr_state;
  power_state_t next_pwr_state;

  // ---------------------------------------------
  // address decode
  // ---------------------------------------------
  wire wr_en_set_lo = i_wr && (i_addr == OFS_EN_SET_LO);
  wire wr_en_set_hi = i_wr && (i_addr == OFS_EN_SET_HI);
  wire wr_en_clr_lo = i_wr && (i_addr == OFS_EN_CLR_LO);
  wire wr_en_clr_hi = i_wr && (i_addr == OFS_EN_CLR_HI);
  wire wr_pset_lo = i_wr && (i_addr == OFS_PEND_SET_LO);
  wire wr_pset_hi = i_wr && (i_addr == OFS_PEND_SET_HI);
  wire wr_pclr_lo = i_wr && (i_addr == OFS_PEND_CLR_LO);
  wire wr_pclr_hi = i_wr && (i_addr == OFS_PEND_CLR_HI);
  wire wr_sys = i_wr && (i_addr == OFS_SYS_CTRL);
  wire prio_hit = (i_addr[11:8] == OFS_PRIO_BASE[11:8]) && (i_addr[1:0] == 2'b00);
  wire wr_prio = i_wr && prio_hit;
  wire [5:0] prio_word = i_addr[7:2];

  // ---------------------------------------------
  // enable set and clear
  // ---------------------------------------------
  // lower and upper enable set
  wire [NUM_IRQ-1:0] en_set =
    (wr_en_set_lo ? field_to_vec(1'b0, i_wdata) : '0) |
    (wr_en_set_hi ? field_to_vec(1'b1, i_wdata) : '0);
  wire [NUM_IRQ-1:0] en_clr =
    (wr_en_clr_lo ? field_to_vec(1'b0, i_wdata) : '0) |
    (wr_en_clr_hi ? field_to_vec(1'b1, i_wdata) : '0);
  wire [NUM_IRQ-1:0] next_enable = (irq_enable & ~en_clr) | en_set;

  // ---------------------------------------------
  // pending set and clear
  // ---------------------------------------------
  // lower and upper pending set
  wire [NUM_IRQ-1:0] sw_pset =
    (wr_pset_lo ? field_to_vec(1'b0, i_wdata) : '0) |
    (wr_pset_hi ? field_to_vec(1'b1, i_wdata) : '0);
  wire [NUM_IRQ-1:0] sw_pclr =
    (wr_pclr_lo ? field_to_vec(1'b0, i_wdata) : '0) |
    (wr_pclr_hi ? field_to_vec(1'b1, i_wdata) : '0);
  wire [NUM_IRQ-1:0] hw_rise = i_irq_line & ~line_q;
  wire [NUM_IRQ-1:0] ack_vec = i_irq_ack ? (NUM_IRQ'(1) << o_irq_num) : '0;
  wire [NUM_IRQ-1:0] next_pending =
    (irq_pending & ~sw_pclr & ~ack_vec) | sw_pset | hw_rise;

  // ---------------------------------------------
  // arbitration
  // ---------------------------------------------
  logic cand_valid;
  logic [7:0] cand_num;
  logic [3:0] cand_prio;

  // lowest value wins, ties to lowest number
  always_comb begin
    cand_valid = 1'b0;
    cand_num = 8'h00;
    cand_prio = 4'hF;
    for (int n = IRQ_FIRST; n < NUM_IRQ; n++) begin
      if (irq_pending[n] && irq_enable[n] && (!cand_valid || prio_mem[n] < cand_prio)) begin
        cand_valid = 1'b1;
        cand_num = 8'(n);
        cand_prio = prio_mem[n];
      end
    end
  end

  wire [3:0] run_prio = stack_prio[0];
  wire may_preempt = (depth == 2'd0) || ((depth == 2'd1) && (cand_prio < run_prio));
  // offer when idle, or at depth 1 when it beats the running level
  wire next_req = cand_valid && may_preempt && !i_irq_ack && !i_irq_ret;

  // ---------------------------------------------
  // nesting stack and active bits
  // ---------------------------------------------
  wire do_push = i_irq_ack && o_irq_req && (depth < 2'(NEST_LEVELS));
  wire do_pop = i_irq_ret && (depth != 2'd0);
  wire [0:0] top_idx = 1'(depth - 2'd1);
  wire [NUM_IRQ-1:0] push_vec = do_push ? (NUM_IRQ'(1) << o_irq_num) : '0;
  wire [NUM_IRQ-1:0] pop_vec = do_pop ? (NUM_IRQ'(1) << stack_num[top_idx]) : '0;
  wire [NUM_IRQ-1:0] next_active = (irq_active & ~pop_vec) | push_vec;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      depth <= 2'd0;
      for (int k = 0; k < NEST_LEVELS; k++) begin
        stack_num[k] <= 8'h00;
        stack_prio[k] <= PRIO_RESET;
      end
    end else if (do_push) begin
      stack_num[depth[0]] <= o_irq_num;
      stack_prio[depth[0]] <= prio_mem[o_irq_num];
      depth <= depth + 2'd1;
    end else if (do_pop) begin
      depth <= depth - 2'd1;
    end
  end

  // ---------------------------------------------
  // interrupt vectors
  // ---------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_enable <= '0;
      irq_pending <= '0;
      irq_active <= '0;
      line_q <= '0;
    end else begin
      irq_enable <= next_enable;
      irq_pending <= next_pending;
      irq_active <= next_active;
      line_q <= i_irq_line;
    end
  end

  // ---------------------------------------------
  // priority slots
  // ---------------------------------------------
  // 256 slots
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int s = 0; s < NUM_PRIO_SLOTS; s++) begin
        prio_mem[s] <= PRIO_RESET;
      end
    end else if (wr_prio) begin
      for (int b = 0; b < 4; b++) begin
        prio_mem[{prio_word, 2'(b)}] <= i_wdata[8*b+4 +: 4];
      end
    end
  end

  wire [31:0] prio_rd = {
    prio_mem[{prio_word, 2'd3}], 4'h0,
    prio_mem[{prio_word, 2'd2}], 4'h0,
    prio_mem[{prio_word, 2'd1}], 4'h0,
    prio_mem[{prio_word, 2'd0}], 4'h0};

  // ---------------------------------------------
  // system control
  // ---------------------------------------------
  // set-event write raises an event
  wire evt_now = (wr_sys && i_wdata[SC_RAISE_EVENT]) || i_event;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      deadlock_off <= SC_BIT_RESET;
      wake_any_pending <= SC_BIT_RESET;
      wfi_as_wfe <= SC_BIT_RESET;
      deep_select <= SC_BIT_RESET;
      sleep_after_handler <= SC_BIT_RESET;
      o_sys_reset <= 1'b0;
    end else begin
      o_sys_reset <= wr_sys && i_wdata[SC_SYS_RESET];
      if (wr_sys) begin
        deadlock_off <= i_wdata[SC_DEADLOCK];
        wake_any_pending <= i_wdata[SC_WAKE_ANY];
        wfi_as_wfe <= i_wdata[SC_WFI_AS_WFE];
        deep_select <= i_wdata[SC_DEEP];
        sleep_after_handler <= i_wdata[SC_SLEEP_EXIT];
      end
    end
  end

  wire [31:0] sys_rd = {
    24'h00_0000, 1'b0, deadlock_off, 1'b0, wake_any_pending,
    wfi_as_wfe, deep_select, sleep_after_handler, 1'b0};

  // ---------------------------------------------
  // wait and sleep control
  // ---------------------------------------------
  wire irq_wake = |(irq_pending & irq_enable);
  // any pending, even disabled, when selected
  wire pend_wake = wake_any_pending ? |irq_pending : irq_wake;
  wire evt_wake = event_flag || evt_now || pend_wake;
  wire wait_evt = i_wfe || (i_wfi && wfi_as_wfe);
  wire wait_irq = i_wfi && !wfi_as_wfe;
  // low power after last handler returns
  wire exit_sleep = do_pop && (depth == 2'd1) && sleep_after_handler;
  logic wake_now;
  logic consume_evt;

  always_comb begin
    next_pwr_state = pwr_state;
    wake_now = 1'b0;
    consume_evt = 1'b0;
    unique case (pwr_state)
      PWR_AWAKE: begin
        if (wait_evt) begin
          // remembered event completes wait at once
          if (evt_wake) begin
            wake_now = 1'b1;
            consume_evt = 1'b1;
          end else begin
            next_pwr_state = PWR_WAIT_EVT;
          end
        end else if (wait_irq) begin
          if (irq_wake) begin
            wake_now = 1'b1;
          end else begin
            next_pwr_state = PWR_WAIT_IRQ;
          end
        end else if (exit_sleep) begin
          next_pwr_state = PWR_WAIT_IRQ;
        end
      end
      PWR_WAIT_IRQ: begin
        if (irq_wake) begin
          wake_now = 1'b1;
          next_pwr_state = PWR_AWAKE;
        end
      end
      PWR_WAIT_EVT: begin
        if (evt_wake) begin
          wake_now = 1'b1;
          consume_evt = 1'b1;
          next_pwr_state = PWR_AWAKE;
        end
      end
    endcase
  end

  // event arriving while a wait is consumed does not linger
  wire next_event_flag = consume_evt ? 1'b0 : (event_flag || evt_now);
  wire next_deep = (next_pwr_state != PWR_AWAKE) && deep_select;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pwr_state <= PWR_AWAKE;
      event_flag <= 1'b0;
      o_sleep <= 1'b0;
      o_sleep_deep <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      pwr_state <= next_pwr_state;
      event_flag <= next_event_flag;
      o_sleep <= next_pwr_state != PWR_AWAKE;
      o_sleep_deep <= next_deep;
      o_wake <= wake_now;
    end
  end

  // ---------------------------------------------
  // core request outputs
  // ---------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq_req <= 1'b0;
      o_irq_num <= 8'h00;
      o_nest_depth <= 2'd0;
      o_deadlock_off <= 1'b0;
    end else begin
      o_irq_req <= next_req;
      o_irq_num <= next_req ? cand_num : o_irq_num;
      o_nest_depth <= do_push ? depth + 2'd1 : (do_pop ? depth - 2'd1 : depth);
      o_deadlock_off <= wr_sys ? i_wdata[SC_DEADLOCK] : deadlock_off;
    end
  end

  // ---------------------------------------------
  // read path
  // ---------------------------------------------
  // write-only and unmapped read zero
  wire [31:0] rd_mux =
    (i_addr == OFS_ACTIVE_LO) ? vec_to_field(1'b0, irq_active) :
    (i_addr == OFS_ACTIVE_HI) ? vec_to_field(1'b1, irq_active) :
    (i_addr == OFS_SYS_CTRL) ? sys_rd :
    prio_hit ? prio_rd : 32'h0000_0000;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
    end
  end

endmodule // vectored_interrupt_ctrl_regs

// *** dv/vectored_interrupt_ctrl_regs_monitor.sv ***
`timescale 1ns/1ps
module vic_monitor
  import vic_pkg::*;
(
  input wire logic i_clk, // clock
  input wire logic i_rst, // reset
  input wire logic [ADDR_W-1:0] i_addr, // address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write
  input wire logic i_rd, // read
  input wire logic [31:0] o_rdata, // read data
  input wire logic i_event, // event
  input wire logic i_irq_ack, // entry
  input wire logic i_irq_ret, // return
  input wire logic i_wfi, // wfi
  input wire logic i_wfe, // wfe
  input wire logic o_irq_req, // offer
  input wire logic [1:0] o_nest_depth, // depth
  input wire logic o_sleep, // asleep
  input wire logic o_sleep_deep, // deep
  input wire logic o_wake, // wake
  input wire logic o_sys_reset, // reset pulse
  input wire logic o_deadlock_off // deadlock off
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  logic sc_wr;
  logic evt_wait;
  logic exit_bit;
  assign sc_wr = i_wr && i_addr == OFS_SYS_CTRL;
  // an event wait may last many cycles, so remember that one is in progress
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_wait <= 1'b0;
      exit_bit <= 1'b0;
    end else begin
      if (i_wfe && !o_sleep) begin
        evt_wait <= 1'b1;
      end else if (o_wake) begin
        evt_wait <= 1'b0;
      end
      if (sc_wr) begin
        exit_bit <= i_wdata[SC_SLEEP_EXIT];
      end
    end
  end
  sequence s_entry;
    i_irq_ack && o_irq_req;
  endsequence
  sequence s_wfe_sleep;
    evt_wait && o_sleep;
  endsequence
  sequence s_raise;
    i_event || (sc_wr && i_wdata[SC_RAISE_EVENT]);
  endsequence
  sequence s_last_return;
    i_irq_ret && o_nest_depth == 2'h1 && exit_bit && !o_sleep && !i_wfe && !i_wfi;
  endsequence
  a_rdata_idle_zero: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0) else $error("read data not zero when idle");
  a_sysrst_pulse: assert property (
    sc_wr && i_wdata[SC_SYS_RESET] |=> o_sys_reset) else $error("no reset pulse");
  a_sysrst_cause: assert property (
    o_sys_reset |-> $past(sc_wr && i_wdata[SC_SYS_RESET])) else $error("reset pulse without write");
  a_deadlock_copy: assert property (
    sc_wr |=> o_deadlock_off == $past(i_wdata[SC_DEADLOCK])) else $error("deadlock bit not taken");
  a_entry_depth: assert property (
    s_entry |=> !o_irq_req && o_nest_depth == $past(o_nest_depth) + 2'h1) else $error("entry not taken");
  a_exit_depth: assert property (
    i_irq_ret && o_nest_depth != 2'h0 |=> o_nest_depth == $past(o_nest_depth) - 2'h1)
    else $error("return not taken");
  a_two_levels: assert property (
    o_nest_depth != 2'h3 && !(o_irq_req && o_nest_depth == 2'h2)) else $error("third level");
  a_event_wakes: assert property (
    s_wfe_sleep ##0 s_raise |=> o_wake && !o_sleep)
    else $error("event did not wake");
  a_exit_sleep: assert property (
    s_last_return |=> o_sleep) else $error("no sleep after last handler");
  a_wake_single: assert property (
    o_wake && !i_wfe && !i_wfi |=> !o_wake) else $error("wake too long");
  a_deep_asleep: assert property (
    o_sleep_deep |-> o_sleep) else $error("deep while awake");
endmodule // vic_monitor

bind vectored_interrupt_ctrl_regs vic_monitor u_mon (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_event, .i_irq_ack, .i_irq_ret, .i_wfi, .i_wfe, .o_irq_req, .o_nest_depth, .o_sleep,
  .o_sleep_deep, .o_wake, .o_sys_reset, .o_deadlock_off);

// *** dv/vic_core_model.sv ***
`timescale 1ns/1ps
module vic_core_model (
  input wire logic i_clk, // clock
  input wire logic i_rst, // sync reset
  input wire logic i_req, // offer seen
  input wire logic i_slow, // late entry
  input wire logic i_hold, // stay in handlers
  output logic o_ack, // entry pulse
  output logic o_ret // return pulse
);
  logic [1:0] depth;
  logic [1:0] seen;
  logic next_ack;
  logic next_ret;
  // never entry and return together; a slow core lets the offer stand 4 cycles
  assign next_ack = i_req && !o_ack && !o_ret && (!i_slow || seen == 2'h3);
  assign next_ret = !next_ack && !o_ack && !o_ret && !i_hold && depth != 2'h0;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ack <= 1'h0;
      o_ret <= 1'h0;
      depth <= 2'h0;
      seen <= 2'h0;
    end else begin
      o_ack <= next_ack;
      o_ret <= next_ret;
      depth <= depth + {1'h0, o_ack} - {1'h0, o_ret};
      seen <= !i_req ? 2'h0 : (seen == 2'h3 ? seen : seen + 2'h1);
    end
  end
endmodule // vic_core_model

// *** dv/vectored_interrupt_ctrl_regs_tb_top.sv ***
`timescale 1ns/1ps
module vectored_interrupt_ctrl_regs_tb_top
  import vic_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [ADDR_W-1:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic rd_q = 1'h0;
  logic ev = 1'h0;
  logic wfi = 1'h0;
  logic wait_for_event_instr = 1'h0;
  logic slow = 1'h1;
  logic hold = 1'h1;
  logic [NUM_IRQ-1:0] line = 36'h0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [7:0] num;
  logic [1:0] depth;
  logic ack, ret, req, sleep, deep, wake, sysrst, dloff;
  logic [31:0] exp_q[$];
  logic [11:0] zs[8] = '{OFS_EN_SET_LO, OFS_EN_CLR_HI, OFS_PEND_SET_HI, OFS_PEND_CLR_LO, OFS_ACTIVE_LO,
    OFS_ACTIVE_HI, OFS_SYS_CTRL, 12'hFFC};
  int ns[4] = '{12, 31, 32, 35};
  int mismatches = 0;
  int n_tests = 0;
  integer seed = 32'h04DAC6A8;
  int k;
  int n;

  always #4 clk = ~clk;

  vectored_interrupt_ctrl_regs dut (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_irq_line(line), .i_event(ev), .i_irq_ack(ack), .i_irq_ret(ret),
    .i_wfi(wfi), .i_wfe(wait_for_event_instr), .o_irq_req(req), .o_irq_num(num), .o_nest_depth(depth), .o_sleep(sleep),
    .o_sleep_deep(deep), .o_wake(wake), .o_sys_reset(sysrst), .o_deadlock_off(dloff));
  vic_core_model core (.i_clk(clk), .i_rst(rst), .i_req(req), .i_slow(slow), .i_hold(hold), .o_ack(ack),
    .o_ret(ret));

  // --------------------------------
  // checking and bus tasks
  // --------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    if (rd_q === 1'h1) begin
      chk(rdata, exp_q.pop_front());
    end
  end

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(posedge clk);
  endtask

  function automatic logic [11:0] hi4(input int i);
    hi4 = i > 31 ? 12'h4 : 12'h0;
  endfunction

  task automatic irq_op(input logic [11:0] base, input int i);
    wr_reg(base + hi4(i), 32'h1 << (i % 32));
  endtask

  task automatic await(input int s, input logic [1:0] v);
    int i;
    for (i = 0; i < 60; i++) begin
      if ((s == 0 ? {1'h0, req} : depth) === v) break;
      @(posedge clk);
    end
    chk({31'h0, i < 60}, 32'h1);
  endtask

  task automatic wait_op(input logic use_wfi, input logic [1:0] e);
    wfi <= use_wfi;
    wait_for_event_instr <= !use_wfi;
    @(posedge clk);
    wfi <= 1'h0;
    wait_for_event_instr <= 1'h0;
    @(posedge clk);
    chk({30'h0, wake, sleep}, {30'h0, e});
  endtask

  task automatic fire_ev(input logic [1:0] e);
    ev <= 1'h1;
    @(posedge clk);
    ev <= 1'h0;
    @(posedge clk);
    chk({30'h0, wake, sleep}, {30'h0, e});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    wr_reg(OFS_ACTIVE_LO, 32'hFFFFFFFF);
    foreach (zs[i]) rd_chk(zs[i], 32'h0);
    for (k = 0; k < PRIO_WORDS; k += 9) begin
      d = $random(seed);
      wr_reg(OFS_PRIO_BASE + 12'(4 * k), d);
      rd_chk(OFS_PRIO_BASE + 12'(4 * k), d & 32'hF0F0F0F0);
    end
    wr_reg(OFS_SYS_CTRL, 32'hFFFFFFFF);
    chk({30'h0, sysrst, dloff}, 32'h3);
    rd_chk(OFS_SYS_CTRL, 32'h5E);
    wr_reg(OFS_SYS_CTRL, 32'h0);
    wait_op(1'h0, 2'h2);
    wr_reg(OFS_SYS_CTRL, 32'h4);
    wait_op(1'h0, 2'h1);
    chk({31'h0, deep}, 32'h1);
    fire_ev(2'h2);
    wr_reg(OFS_SYS_CTRL, 32'h8);
    fire_ev(2'h0);
    wait_op(1'h1, 2'h2);
    wait_op(1'h0, 2'h1);
    wr_reg(OFS_SYS_CTRL, 32'h20);
    chk({30'h0, wake, sleep}, 32'h2);
    wr_reg(OFS_SYS_CTRL, 32'h10);
    irq_op(OFS_PEND_SET_LO, 25);
    wait_op(1'h0, 2'h2);
    irq_op(OFS_PEND_CLR_LO, 25);
    foreach (ns[i]) begin
      n = ns[i];
      irq_op(OFS_PEND_SET_LO, n);
      irq_op(OFS_PEND_CLR_LO, n);
      irq_op(OFS_EN_SET_LO, n);
      repeat (3) @(posedge clk);
      chk({31'h0, req}, 32'h0);
      irq_op(OFS_EN_CLR_LO, n);
      irq_op(OFS_PEND_SET_LO, n);
      repeat (3) @(posedge clk);
      chk({31'h0, req}, 32'h0);
      irq_op(OFS_EN_SET_LO, n);
      await(0, 2'h1);
      chk({24'h0, num}, 32'(n));
      await(1, 2'h1);
      rd_chk(OFS_ACTIVE_LO + hi4(n), 32'h1 << (n % 32));
      hold <= 1'h0;
      await(1, 2'h0);
      hold <= 1'h1;
      rd_chk(OFS_ACTIVE_LO + hi4(n), 32'h0);
    end
    slow <= 1'h0;
    wr_reg(OFS_PRIO_BASE + 12'h14, 32'h204080FF);
    rd_chk(OFS_PRIO_BASE + 12'h14, 32'h204080F0);
    wr_reg(OFS_EN_SET_LO, 32'h00F00000);
    wr_reg(OFS_PEND_SET_LO, 32'h00200000);
    await(1, 2'h1);
    wr_reg(OFS_PEND_SET_LO, 32'h00500000);
    await(0, 2'h1);
    chk({24'h0, num}, 32'h16);
    await(1, 2'h2);
    wr_reg(OFS_PEND_SET_LO, 32'h00800000);
    repeat (3) @(posedge clk);
    chk({29'h0, req, depth}, 32'h2);
    rd_chk(OFS_ACTIVE_LO, 32'h00600000);
    hold <= 1'h0;
    await(1, 2'h0);
    hold <= 1'h1;
    rd_chk(OFS_ACTIVE_LO, 32'h0);
    wr_reg(OFS_EN_SET_LO, 32'h01000000);
    fork
      wr_reg(OFS_PEND_CLR_LO, 32'h01000000);
      line[24] <= 1'h1;
    join
    await(0, 2'h1);
    chk({24'h0, num}, 32'h18);
    wr_reg(OFS_SYS_CTRL, 32'h2);
    hold <= 1'h0;
    await(1, 2'h0);
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule // vectored_interrupt_ctrl_regs_tb_top
